// File: hw/dppa_top.sv
// Dual port peripheral adapter: bus decode, port registers, pins
`timescale 1ns/100ps
`default_nettype none
module dppa_top #(
  parameter int unsigned WIDTH = dppa_pkg::PORT_W
) (
  // Clock and resets
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             init_n,
  // Processor bus
  input  wire logic             phase2,
  input  wire logic             sel_hi_0,
  input  wire logic             sel_hi_1,
  input  wire logic             sel_lo_n,
  input  wire logic             reg_sel_high,
  input  wire logic             reg_sel_low,
  input  wire logic             rd_wr,
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic                  data_oe_n,
  // Port A pins
  input  wire logic [WIDTH-1:0] port_a_lines_in,
  output logic      [WIDTH-1:0] port_a_lines_out,
  output logic      [WIDTH-1:0] port_a_lines_oe_n,
  // Port B pins
  input  wire logic [WIDTH-1:0] port_b_lines_in,
  output logic      [WIDTH-1:0] port_b_lines_out,
  output logic      [WIDTH-1:0] port_b_lines_oe_n,
  // Control lines
  input  wire logic             ctl_in_a1,
  input  wire logic             ctl_io_a2,
  input  wire logic             ctl_in_b1,
  input  wire logic             ctl_io_b2,
  // Open-drain requests
  output logic                  int_req_a_n_out,
  output logic                  int_req_a_n_oe_n,
  output logic                  int_req_b_n_out,
  output logic                  int_req_b_n_oe_n
);
  logic             clr;
  logic             chipSel;
  logic [1:0]       regSel;
  logic             phase2_q;
  logic             p2Fall;
  logic [7:0]       dataLatch_q;
  logic [1:0]       wrSel_q;
  logic             wrPend_q;
  logic [1:0]       rdSel_q;
  logic             rdPend_q;
  logic             commit;
  logic [5:0]       ctrlA_q;
  logic [5:0]       ctrlB_q;
  logic [WIDTH-1:0] dirA_q;
  logic [WIDTH-1:0] dirB_q;
  logic [WIDTH-1:0] outA_q;
  logic [WIDTH-1:0] outB_q;
  logic [7:0]       ctrlRdA;
  logic [7:0]       ctrlRdB;
  logic [WIDTH-1:0] portBRead;
  logic [7:0]       dataOut_d;
  logic [7:0]       dataOut_q;
  logic             edgeA1;
  logic             edgeA2;
  logic             edgeB1;
  logic             edgeB2;
  logic             clrA;
  logic             clrB;
  logic             wrCtrlA;
  logic             wrCtrlB;
  logic             wrDirA;
  logic             wrDirB;
  logic             wrOutA;
  logic             wrOutB;
  dppa_irq_if int_req_a_n ();
  dppa_irq_if int_req_b_n ();
  // reset pin clears like the core reset
  assign clr = ~rst_n | ~init_n;
  assign chipSel = sel_hi_0 & sel_hi_1 & ~sel_lo_n;
  assign regSel  = {reg_sel_high, reg_sel_low};
  always_ff @(posedge core_clk) begin
    if (clr) begin
      phase2_q <= 1'b0;
    end else if (clk_en) begin
      phase2_q <= phase2;
    end
  end
  assign p2Fall = phase2_q & ~phase2;
  // write data held until phase two falls
  always_ff @(posedge core_clk) begin
    if (clr) begin
      dataLatch_q <= dppa_pkg::RST_REG;
      wrSel_q     <= 2'h0;
      wrPend_q    <= 1'b0;
    end else if (clk_en) begin
      if (phase2 && chipSel && !rd_wr) begin
        dataLatch_q <= data_in;
        wrSel_q     <= regSel;
        wrPend_q    <= 1'b1;
      end else if (p2Fall) begin
        wrPend_q    <= 1'b0;
      end
    end
  end

  // A read counts once, at the end of its phase two pulse
  always_ff @(posedge core_clk) begin
    if (clr) begin
      rdSel_q  <= 2'h0;
      rdPend_q <= 1'b0;
    end else if (clk_en) begin
      if (phase2 && chipSel && rd_wr) begin
        rdSel_q  <= regSel;
        rdPend_q <= 1'b1;
      end else if (p2Fall) begin
        rdPend_q <= 1'b0;
      end
    end
  end

  assign commit = p2Fall & wrPend_q;
  assign wrCtrlA = commit && wrSel_q == dppa_pkg::SEL_CTRL_A;
  assign wrCtrlB = commit && wrSel_q == dppa_pkg::SEL_CTRL_B;
  assign wrOutA  = commit && wrSel_q == dppa_pkg::SEL_DATA_A
                   && ctrlA_q[dppa_pkg::BIT_ACC];
  assign wrDirA  = commit && wrSel_q == dppa_pkg::SEL_DATA_A
                   && !ctrlA_q[dppa_pkg::BIT_ACC];
  assign wrOutB  = commit && wrSel_q == dppa_pkg::SEL_DATA_B
                   && ctrlB_q[dppa_pkg::BIT_ACC];
  assign wrDirB  = commit && wrSel_q == dppa_pkg::SEL_DATA_B
                   && !ctrlB_q[dppa_pkg::BIT_ACC];

  // writable registers, flags are not writable
  always_ff @(posedge core_clk) begin
    if (clr) begin
      ctrlA_q <= dppa_pkg::RST_CFG;
    end else if (clk_en && wrCtrlA) begin
      ctrlA_q <= dataLatch_q[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      ctrlB_q <= dppa_pkg::RST_CFG;
    end else if (clk_en && wrCtrlB) begin
      ctrlB_q <= dataLatch_q[5:0];
    end
  end

  // direction cleared, every line an input
  always_ff @(posedge core_clk) begin
    if (clr) begin
      dirA_q <= '0;
      dirB_q <= '0;
    end else if (clk_en) begin
      if (wrDirA) begin
        dirA_q <= dataLatch_q[WIDTH-1:0];
      end
      if (wrDirB) begin
        dirB_q <= dataLatch_q[WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      outA_q <= '0;
      outB_q <= '0;
    end else if (clk_en) begin
      if (wrOutA) begin
        outA_q <= dataLatch_q[WIDTH-1:0];
      end
      if (wrOutB) begin
        outB_q <= dataLatch_q[WIDTH-1:0];
      end
    end
  end

  // driven value is the output register
  assign port_a_lines_out  = outA_q;
  assign port_a_lines_oe_n = ~dirA_q;
  // input lines of port B float
  assign port_b_lines_out  = outB_q;
  assign port_b_lines_oe_n = ~dirB_q;

  // polarity from bits 1 and 4
  dppa_edge_det u_edge_a1 (
    .core_clk (core_clk),
    .clr      (clr),
    .clk_en   (clk_en),
    .line     (ctl_in_a1),
    .rising   (ctrlA_q[dppa_pkg::BIT_EDGE1]),
    .pulse    (edgeA1)
  );
  dppa_edge_det u_edge_a2 (
    .core_clk (core_clk),
    .clr      (clr),
    .clk_en   (clk_en),
    .line     (ctl_io_a2),
    .rising   (ctrlA_q[dppa_pkg::BIT_EDGE2]),
    .pulse    (edgeA2)
  );
  dppa_edge_det u_edge_b1 (
    .core_clk (core_clk),
    .clr      (clr),
    .clk_en   (clk_en),
    .line     (ctl_in_b1),
    .rising   (ctrlB_q[dppa_pkg::BIT_EDGE1]),
    .pulse    (edgeB1)
  );
  dppa_edge_det u_edge_b2 (
    .core_clk (core_clk),
    .clr      (clr),
    .clk_en   (clk_en),
    .line     (ctl_io_b2),
    .rising   (ctrlB_q[dppa_pkg::BIT_EDGE2]),
    .pulse    (edgeB2)
  );

  // a port's data read with its access bit set clears that port's flags
  assign clrA = commit ? 1'b0 : (p2Fall && rdPend_q
                && rdSel_q == dppa_pkg::SEL_DATA_A
                && ctrlA_q[dppa_pkg::BIT_ACC]);
  assign clrB = commit ? 1'b0 : (p2Fall && rdPend_q
                && rdSel_q == dppa_pkg::SEL_DATA_B
                && ctrlB_q[dppa_pkg::BIT_ACC]);

  // first line feeds flag 7, enable 0
  // second line feeds flag 6, enable 3
  // Second line counts only while it is in input mode
  assign int_req_a_n.edge1 = edgeA1;
  assign int_req_a_n.edge2 = edgeA2 & ~ctrlA_q[dppa_pkg::BIT_MODE2];
  assign int_req_a_n.clear = clrA;
  assign int_req_a_n.en1   = ctrlA_q[dppa_pkg::BIT_EN1];
  assign int_req_a_n.en2   = ctrlA_q[dppa_pkg::BIT_EN2];
  assign int_req_b_n.edge1 = edgeB1;
  assign int_req_b_n.edge2 = edgeB2 & ~ctrlB_q[dppa_pkg::BIT_MODE2];
  assign int_req_b_n.clear = clrB;
  assign int_req_b_n.en1   = ctrlB_q[dppa_pkg::BIT_EN1];
  assign int_req_b_n.en2   = ctrlB_q[dppa_pkg::BIT_EN2];

  dppa_irq_flags u_flags_a (
    .core_clk (core_clk),
    .clr      (clr),
    .clk_en   (clk_en),
    .irq_io   (int_req_a_n.flg)
  );
  dppa_irq_flags u_flags_b (
    .core_clk (core_clk),
    .clr      (clr),
    .clk_en   (clk_en),
    .irq_io   (int_req_b_n.flg)
  );
  // pull low or release, never drive high
  assign int_req_a_n_out  = 1'b0;
  assign int_req_a_n_oe_n = ~int_req_a_n.irq;
  assign int_req_b_n_out  = 1'b0;
  assign int_req_b_n_oe_n = ~int_req_b_n.irq;
  assign ctrlRdA = {int_req_a_n.flag1, int_req_a_n.flag2, ctrlA_q};
  assign ctrlRdB = {int_req_b_n.flag1, int_req_b_n.flag2, ctrlB_q};
  // port B outputs read from register
  assign portBRead = (outB_q & dirB_q) | (port_b_lines_in & ~dirB_q);

  always_comb begin
    dataOut_d = dppa_pkg::RST_REG;
    unique case (regSel)
      dppa_pkg::SEL_DATA_A: begin
        dataOut_d[WIDTH-1:0] = ctrlA_q[dppa_pkg::BIT_ACC] ?
                               port_a_lines_in : dirA_q;
      end
      dppa_pkg::SEL_CTRL_A: begin
        dataOut_d = ctrlRdA;
      end
      dppa_pkg::SEL_DATA_B: begin
        dataOut_d[WIDTH-1:0] = ctrlB_q[dppa_pkg::BIT_ACC] ?
                               portBRead : dirB_q;
      end
      dppa_pkg::SEL_CTRL_B: begin
        dataOut_d = ctrlRdB;
      end
    endcase
  end

  // Read data registered one cycle behind the select lines
  always_ff @(posedge core_clk) begin
    if (clr) begin
      dataOut_q <= dppa_pkg::RST_REG;
    end else if (clk_en) begin
      dataOut_q <= dataOut_d;
    end
  end

  assign data_out = dataOut_q;
  // drive only while selected for a read
  assign data_oe_n = ~(chipSel & rd_wr);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (clr);

  a_bus_float: assert property (!chipSel |-> data_oe_n)
    else $error("Data bus driven while unselected");
  a_port_a_drive: assert property (
    ((~port_a_lines_oe_n) & (port_a_lines_out ^ outA_q)) == '0)
    else $error("Port A output differs from output register");
  a_irq_level: assert property (
    int_req_a_n_oe_n == !((ctrlRdA[7] && ctrlRdA[0])
                          || (ctrlRdA[6] && ctrlRdA[3])))
    else $error("Port A request mismatches flags");
  a_flag_a_set: assert property (
    edgeA1 |=> ctrlRdA[dppa_pkg::BIT_FLAG1])
    else $error("Flag 7 not set by edge");
  a_flag_clear_read: assert property (
    clk_en && clrA && !edgeA1 && !int_req_a_n.edge2 |=> !ctrlRdA[7] && !ctrlRdA[6])
    else $error("Port A data read left flags set");
  a_set_wins: assert property (
    clk_en && clrB && edgeB1 |=> ctrlRdB[dppa_pkg::BIT_FLAG1])
    else $error("Edge lost against clearing read");
  a_write_commit: assert property (
    clk_en && commit && wrSel_q == dppa_pkg::SEL_CTRL_A
    |=> ctrlA_q == $past(dataLatch_q[5:0]))
    else $error("Control A write not committed");
  a_port_b_read: assert property (
    clk_en && regSel == dppa_pkg::SEL_DATA_B && ctrlB_q[dppa_pkg::BIT_ACC]
    && !commit |=> data_out[WIDTH-1:0] == $past(portBRead))
    else $error("Port B read data wrong");
  a_port_a_read: assert property (
    clk_en && regSel == dppa_pkg::SEL_DATA_A && ctrlA_q[dppa_pkg::BIT_ACC]
    |=> data_out[WIDTH-1:0] == $past(port_a_lines_in))
    else $error("Port A read did not return pins");
  a_reset_inputs: assert property (
    disable iff (!rst_n) !init_n && clk_en
    |=> port_a_lines_oe_n == '1 && port_b_lines_oe_n == '1)
    else $error("Ports not inputs after reset");

  c_flag_a1: cover property (edgeA1 ##1 !int_req_a_n_oe_n);
  c_clear_read: cover property (ctrlRdA[7] && clrA);
  c_write_b_out: cover property (wrOutB ##1 !port_b_lines_oe_n[0]);
  c_edge_b2: cover property (int_req_b_n.edge2 && ctrlB_q[dppa_pkg::BIT_EN2]);
endmodule : dppa_top
`default_nettype wire

// File: hw/dppa_pkg.sv
// Shared constants of the dual port peripheral adapter
package dppa_pkg;
  // Widths
  localparam int unsigned PORT_W = 8;
  localparam int unsigned CFG_W  = 6;
  // Register select codes {reg_sel_high, reg_sel_low}
  localparam logic [1:0] SEL_DATA_A = 2'h0;
  localparam logic [1:0] SEL_CTRL_A = 2'h1;
  localparam logic [1:0] SEL_DATA_B = 2'h2;
  localparam logic [1:0] SEL_CTRL_B = 2'h3;
  // Control register fields
  localparam int unsigned BIT_EN1   = 0;
  localparam int unsigned BIT_EDGE1 = 1;
  localparam int unsigned BIT_ACC   = 2;
  localparam int unsigned BIT_EN2   = 3;
  localparam int unsigned BIT_EDGE2 = 4;
  localparam int unsigned BIT_MODE2 = 5;
  localparam int unsigned BIT_FLAG2 = 6;
  localparam int unsigned BIT_FLAG1 = 7;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [5:0] RST_CFG = 6'h00;
endpackage : dppa_pkg

// File: hw/dppa_irq_if.sv
// Carrier between the top and one interrupt flag section
`timescale 1ns/100ps
`default_nettype none
interface dppa_irq_if;
  logic edge1;
  logic edge2;
  logic clear;
  logic en1;
  logic en2;
  logic flag1;
  logic flag2;
  logic irq;
  modport ctl (output edge1, edge2, clear, en1, en2,
               input  flag1, flag2, irq);
  modport flg (input  edge1, edge2, clear, en1, en2,
               output flag1, flag2, irq);
endinterface : dppa_irq_if
`default_nettype wire

// File: hw/dppa_edge_det.sv
// Sampled edge detector for one control line
`timescale 1ns/100ps
`default_nettype none
module dppa_edge_det (
  // Clocking
  input  wire logic core_clk,
  input  wire logic clr,
  input  wire logic clk_en,
  // Line and polarity
  input  wire logic line,
  input  wire logic rising,
  // Event
  output logic      pulse
);
  logic prev_q;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= line;
    end
  end

  // Edge polarity picked by the control bit, not latched; a steady line
  // gives no pulse under either polarity, so a polarity change is no edge
  assign pulse = clk_en & (rising ? (line & ~prev_q) : (~line & prev_q));
endmodule : dppa_edge_det
`default_nettype wire

// File: hw/dppa_irq_flags.sv
// Two sticky interrupt flags and the request of one port
`timescale 1ns/100ps
`default_nettype none
module dppa_irq_flags (
  // Clocking
  input  wire logic core_clk,
  input  wire logic clr,
  input  wire logic clk_en,
  // Section carrier
  dppa_irq_if.flg   irq_io
);
  logic flag1_q;
  logic flag2_q;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      flag1_q <= 1'b0;
    end else if (clk_en) begin
      flag1_q <= irq_io.edge1 | (flag1_q & ~irq_io.clear);
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      flag2_q <= 1'b0;
    end else if (clk_en) begin
      flag2_q <= irq_io.edge2 | (flag2_q & ~irq_io.clear);
    end
  end

  assign irq_io.flag1 = flag1_q;
  assign irq_io.flag2 = flag2_q;
  assign irq_io.irq = (flag1_q & irq_io.en1) | (flag2_q & irq_io.en2);
endmodule : dppa_irq_flags
`default_nettype wire

// File: sim/dppa_periph_model.sv
// Peripheral side model that resolves the port pin levels
`timescale 1ns/100ps
`default_nettype none
module dppa_periph_model (
  // Device pin drive
  input  wire logic [7:0] aOut,
  input  wire logic [7:0] aOeN,
  input  wire logic [7:0] bOut,
  input  wire logic [7:0] bOeN,
  // Peripheral drive and load
  input  wire logic [7:0] aExt,
  input  wire logic [7:0] aLoad,
  input  wire logic [7:0] bExt,
  // Resolved pins
  output logic      [7:0] aPin,
  output logic      [7:0] bPin
);
  // A loaded line driven by the device never reaches a high level, so it reads low
  // Same load on port B, whose reads must not see it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      aPin[i] = !aOeN[i] ? (aOut[i] & ~aLoad[i]) : aExt[i];
      bPin[i] = !bOeN[i] ? (bOut[i] & ~aLoad[i]) : bExt[i];
    end
  end
endmodule // dppa_periph_model
`default_nettype wire

// File: sim/dppa_top_tb.sv
// Self-checking bench of the dual port peripheral adapter
`timescale 1ns/100ps
`default_nettype none
module dppa_top_tb;
  logic       coreClk, rstN, initN, phase2, selHi0, selLoN, rdWr, rdTake;
  logic [1:0] regSel, lnA, lnB, mm, cs, ds;
  logic [7:0] dataIn, dataOut, aOut, aOeN, bOut, bOeN, aPin, bPin;
  logic [7:0] aExt, aLoad, bExt, cfg, expA, expB;
  logic [7:0] dirV [2];
  logic [7:0] outV [2];
  logic       dataOeN, reqAOut, reqAOeN, reqBOut, reqBOeN, clkEn;
  logic [7:0] expQ [$];
  int         errTotal, nTests;

  dppa_top u_dppa_top (
    .core_clk(coreClk), .rst_n(rstN), .clk_en(clkEn), .init_n(initN),
    .phase2(phase2), .sel_hi_0(selHi0), .sel_hi_1(1'b1),
    .sel_lo_n(selLoN), .reg_sel_high(regSel[1]), .reg_sel_low(regSel[0]),
    .rd_wr(rdWr), .data_in(dataIn), .data_out(dataOut),
    .data_oe_n(dataOeN), .port_a_lines_in(aPin), .port_a_lines_out(aOut),
    .port_a_lines_oe_n(aOeN), .port_b_lines_in(bPin),
    .port_b_lines_out(bOut), .port_b_lines_oe_n(bOeN),
    .ctl_in_a1(lnA[0]), .ctl_io_a2(lnA[1]), .ctl_in_b1(lnB[0]),
    .ctl_io_b2(lnB[1]), .int_req_a_n_out(reqAOut),
    .int_req_a_n_oe_n(reqAOeN), .int_req_b_n_out(reqBOut),
    .int_req_b_n_oe_n(reqBOeN));

  dppa_periph_model u_dppa_periph_model (
    .aOut(aOut), .aOeN(aOeN), .bOut(bOut), .bOeN(bOeN), .aExt(aExt),
    .aLoad(aLoad), .bExt(bExt), .aPin(aPin), .bPin(bPin));

  always #5 coreClk = ~coreClk;

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One bus access per phase two pulse, selects held through the fall
  task automatic bus(input logic [1:0] sel, input logic rw,
                     input logic [7:0] wd, input logic sl,
                     input logic chk, input logic [7:0] e);
    @(posedge coreClk);
    selHi0 <= sl;
    selLoN <= ~sl;
    regSel <= sel;
    rdWr   <= rw;
    dataIn <= wd;
    phase2 <= 1'b1;
    @(posedge coreClk);
    phase2 <= 1'b0;
    if (!sl) chk1("bus float", 1'b1, dataOeN);
    if (rw && chk) begin
      expQ.push_back(e);
      rdTake <= 1'b1;
    end
    @(posedge coreClk);
    selHi0 <= 1'b0;
    selLoN <= 1'b1;
    rdWr   <= 1'b1;
    rdTake <= 1'b0;
    @(posedge coreClk);
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    bus(s, 1'b0, d, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    bus(s, 1'b1, 8'h00, 1'b1, 1'b1, e);
  endtask

  task automatic setLn(input int p, input int k, input logic v);
    @(posedge coreClk);
    if (p != 0) lnB[k] <= v;
    else lnA[k] <= v;
  endtask

  task automatic irqIs(input int p, input logic e);
    repeat (4) @(posedge coreClk);
    chk1("request", e, (p != 0) ? reqBOeN : reqAOeN);
  endtask

  // Read results are taken off the queue as they appear
  always @(negedge coreClk) begin
    if (rdTake) begin
      chk8("read data", expQ.pop_front(), dataOut);
      chk1("bus drive", 1'b0, dataOeN);
    end
  end

  initial begin
    repeat (20000) @(posedge coreClk);
    errTotal++;
    completeRun();
  end

  initial begin
    {coreClk, rstN, phase2, selHi0, rdWr, rdTake} = '0;
    {initN, selLoN, clkEn} = 3'b111;
    {regSel, lnA, lnB, dataIn} = '0;
    void'($urandom(4));
    aExt  = $urandom;
    aLoad = $urandom;
    bExt  = $urandom;
    repeat (6) @(posedge coreClk);
    rstN <= 1'b1;
    // Reset state, refused accesses, read-only flag bits
    for (int s = 0; s < 4; s++) rd(s[1:0], 8'h00);
    chk8("dir a", 8'hff, aOeN & bOeN);
    bus(dppa_pkg::SEL_CTRL_A, 1'b0, 8'hff, 1'b0, 1'b0, 8'h00);
    bus(dppa_pkg::SEL_CTRL_A, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00);
    rd(dppa_pkg::SEL_CTRL_A, 8'h00);
    wr(dppa_pkg::SEL_CTRL_A, 8'hc5);
    rd(dppa_pkg::SEL_CTRL_A, 8'h05);
    chk1("request level", 1'b0, reqAOut | reqBOut);
    $display("test reset finished");
    // Direction and output registers behind the access bit
    for (int p = 0; p < 2; p++) begin
      cs = (p != 0) ? dppa_pkg::SEL_CTRL_B : dppa_pkg::SEL_CTRL_A;
      ds = (p != 0) ? dppa_pkg::SEL_DATA_B : dppa_pkg::SEL_DATA_A;
      dirV[p] = $urandom;
      outV[p] = $urandom;
      wr(cs, 8'h00);
      wr(ds, dirV[p]);
      rd(ds, dirV[p]);
      wr(cs, 8'h04);
      wr(ds, outV[p]);
    end
    expA = (outV[0] & ~aLoad & dirV[0]) | (aExt & ~dirV[0]);
    expB = (outV[1] & dirV[1]) | (bExt & ~dirV[1]);
    chk8("oe a", ~dirV[0], aOeN);
    chk8("oe b", ~dirV[1], bOeN);
    chk8("out a", outV[0], aOut);
    rd(dppa_pkg::SEL_DATA_A, expA);
    rd(dppa_pkg::SEL_DATA_B, expB);
    $display("test ports finished");
    // Flags per edge polarity and enable, both sections
    for (int p = 0; p < 2; p++) begin
      cs = (p != 0) ? dppa_pkg::SEL_CTRL_B : dppa_pkg::SEL_CTRL_A;
      ds = (p != 0) ? dppa_pkg::SEL_DATA_B : dppa_pkg::SEL_DATA_A;
      for (int m = 0; m < 4; m++) begin
        mm  = m[1:0];
        cfg = {3'b000, mm[1], mm[0] ^ mm[1], 1'b1, mm[1], mm[0]};
        setLn(p, 0, ~mm[1]);
        setLn(p, 1, ~mm[1]);
        wr(cs, cfg);
        repeat (4) @(posedge coreClk);
        bus(ds, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00);
        rd(cs, cfg);
        setLn(p, 1, mm[1]);
        irqIs(p, ~cfg[3]);
        rd(cs, cfg | 8'h40);
        setLn(p, 0, mm[1]);
        irqIs(p, ~(cfg[0] | cfg[3]));
        rd(cs, cfg | 8'hc0);
        bus(ds, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00);
        irqIs(p, 1'b1);
        rd(cs, cfg);
        setLn(p, 0, ~mm[1]);
        setLn(p, 1, ~mm[1]);
        irqIs(p, 1'b1);
        rd(cs, cfg);
      end
      $display("test flags %0d finished", p);
    end
    // Frozen clock enable, masked second line, edge against clearing read
    @(posedge coreClk);
    clkEn <= 1'b0;
    setLn(0, 0, 1'b1);
    irqIs(0, 1'b1);
    @(posedge coreClk);
    clkEn <= 1'b1;
    irqIs(0, 1'b0);
    bus(dppa_pkg::SEL_DATA_A, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00);
    wr(dppa_pkg::SEL_CTRL_A, 8'h2c);
    setLn(0, 1, 1'b1);
    setLn(0, 1, 1'b0);
    irqIs(0, 1'b1);
    rd(dppa_pkg::SEL_CTRL_A, 8'h2c);
    fork
      bus(dppa_pkg::SEL_DATA_B, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00);
      begin
        repeat (2) @(posedge coreClk);
        lnB[0] <= 1'b1;
      end
    join
    rd(dppa_pkg::SEL_CTRL_B, 8'h97);
    $display("test extras finished");
    // Second reset pin mid-run
    @(posedge coreClk);
    initN <= 1'b0;
    repeat (2) @(posedge coreClk);
    initN <= 1'b1;
    rd(dppa_pkg::SEL_CTRL_B, 8'h00);
    chk8("oe after init", 8'hff, aOeN & bOeN);
    $display("test init finished");
    repeat (3) @(posedge coreClk);
    completeRun();
  end
endmodule // dppa_top_tb
`default_nettype wire
